// ==== verilog/cpr_pkg.sv ====
// package: register map, field layout, reset values and carrier types for codec path routing
package cpr_pkg;

  localparam int unsigned CPR_NUM_REGS   = 8;
  localparam int unsigned CPR_SAMPLE_W   = 24;
  localparam int unsigned CPR_WORD_W     = 9;

  // register offsets on the control port
  localparam logic [6:0] CPR_OFS_DAC1_SRC  = 7'h0c;
  localparam logic [6:0] CPR_OFS_PRI_TX    = 7'h0d;
  localparam logic [6:0] CPR_OFS_SEC_TX    = 7'h0e;
  localparam logic [6:0] CPR_OFS_DAC_CTRL1 = 7'h0f;
  localparam logic [6:0] CPR_OFS_DEEMPH    = 7'h11;
  localparam logic [6:0] CPR_OFS_POLARITY  = 7'h12;
  localparam logic [6:0] CPR_OFS_ADC_FUNC  = 7'h1d;
  localparam logic [6:0] CPR_OFS_SPDIF_TX  = 7'h1e;

  // storage slots
  localparam logic [2:0] CPR_IDX_DAC1_SRC  = 3'h0;
  localparam logic [2:0] CPR_IDX_PRI_TX    = 3'h1;
  localparam logic [2:0] CPR_IDX_SEC_TX    = 3'h2;
  localparam logic [2:0] CPR_IDX_DAC_CTRL1 = 3'h3;
  localparam logic [2:0] CPR_IDX_DEEMPH    = 3'h4;
  localparam logic [2:0] CPR_IDX_POLARITY  = 3'h5;
  localparam logic [2:0] CPR_IDX_ADC_FUNC  = 3'h6;
  localparam logic [2:0] CPR_IDX_SPDIF_TX  = 3'h7;

  // reset values
  localparam logic [8:0] CPR_RST_DAC1_SRC  = 9'h180;
  localparam logic [8:0] CPR_RST_PRI_TX    = 9'h080;
  localparam logic [8:0] CPR_RST_SEC_TX    = 9'h000;
  localparam logic [8:0] CPR_RST_DAC_CTRL1 = 9'h000;
  localparam logic [8:0] CPR_RST_DEEMPH    = 9'h000;
  localparam logic [8:0] CPR_RST_POLARITY  = 9'h03f;
  localparam logic [8:0] CPR_RST_ADC_FUNC  = 9'h040;
  localparam logic [8:0] CPR_RST_SPDIF_TX  = 9'h000;

  // field positions
  localparam int unsigned CPR_SRC_LSB        = 7;
  localparam int unsigned CPR_RX2DAC_BIT     = 8;
  localparam int unsigned CPR_DEEMPH_LSB     = 0;
  localparam int unsigned CPR_DEEMPH_ALL_BIT = 4;
  localparam int unsigned CPR_POLARITY_LSB   = 0;
  localparam int unsigned CPR_MUTE_L_BIT     = 0;
  localparam int unsigned CPR_MUTE_R_BIT     = 1;
  localparam int unsigned CPR_MUTE_BOTH_BIT  = 2;
  localparam int unsigned CPR_OSR_BIT        = 3;
  localparam int unsigned CPR_HPD_BIT        = 4;
  localparam int unsigned CPR_SPDIF_SRC_LSB  = 0;
  localparam int unsigned CPR_THROUGH_BIT    = 3;

  // source codes
  localparam logic [1:0] CPR_SRC_SPDIF = 2'h0;
  localparam logic [1:0] CPR_SRC_ADC   = 2'h1;
  localparam logic [1:0] CPR_SRC_SEC   = 2'h2;
  localparam logic [1:0] CPR_SRC_PRI   = 2'h3;

  // master clock ratio codes, and adc oversampling codes
  localparam logic [2:0] CPR_RATIO_128FS = 3'h0;
  localparam logic [2:0] CPR_RATIO_192FS = 3'h1;
  localparam logic [1:0] CPR_OSR_128FS   = 2'h0;
  localparam logic [1:0] CPR_OSR_64FS    = 2'h1;
  localparam logic [1:0] CPR_OSR_32FS    = 2'h2;

  localparam logic [23:0] CPR_SAMPLE_MIN = 24'h800000;
  localparam logic [23:0] CPR_SAMPLE_MAX = 24'h7fffff;

  typedef logic [CPR_NUM_REGS-1:0][CPR_WORD_W-1:0] cpr_words_t;

  localparam cpr_words_t CPR_RST_WORDS = {CPR_RST_SPDIF_TX, CPR_RST_ADC_FUNC,
                                          CPR_RST_POLARITY, CPR_RST_DEEMPH,
                                          CPR_RST_DAC_CTRL1, CPR_RST_SEC_TX,
                                          CPR_RST_PRI_TX, CPR_RST_DAC1_SRC};

  typedef struct packed {
    logic [CPR_SAMPLE_W-1:0] left;
    logic [CPR_SAMPLE_W-1:0] right;
  } cpr_sample_t;

  typedef struct packed {
    logic [1:0] dac1_source_field;
    logic [1:0] primary_tx_source_field;
    logic [1:0] secondary_tx_source_field;
    logic [1:0] spdif_tx_source_field;
    logic       spdif_through;
    logic       receive_to_dac_mode;
    logic [2:0] per_dac_deemph_enable;
    logic       deemph_all_dacs;
    logic [5:0] output_polarity;
    logic       adc_highpass_disable;
    logic       adc_oversample_select;
    logic       adc_left_mute;
    logic       adc_right_mute;
    logic       adc_both_mute;
    logic [2:0][1:0] din_route;
  } cpr_cfg_t;

  // address decode shared by the read and write sides: {hit, slot}
  function automatic logic [3:0] cpr_decode(input logic [6:0] addr);
    case (addr)
      CPR_OFS_DAC1_SRC:  cpr_decode = {1'b1, CPR_IDX_DAC1_SRC};
      CPR_OFS_PRI_TX:    cpr_decode = {1'b1, CPR_IDX_PRI_TX};
      CPR_OFS_SEC_TX:    cpr_decode = {1'b1, CPR_IDX_SEC_TX};
      CPR_OFS_DAC_CTRL1: cpr_decode = {1'b1, CPR_IDX_DAC_CTRL1};
      CPR_OFS_DEEMPH:    cpr_decode = {1'b1, CPR_IDX_DEEMPH};
      CPR_OFS_POLARITY:  cpr_decode = {1'b1, CPR_IDX_POLARITY};
      CPR_OFS_ADC_FUNC:  cpr_decode = {1'b1, CPR_IDX_ADC_FUNC};
      CPR_OFS_SPDIF_TX:  cpr_decode = {1'b1, CPR_IDX_SPDIF_TX};
      default:           cpr_decode = 4'h0;
    endcase
  endfunction

endpackage

// ==== verilog/cpr_regfile.sv ====
// control register storage with registered readback
`timescale 1ns/100ps
module cpr_regfile
  import cpr_pkg::*;
(
  input  wire logic             sys_clk,    // system clock
  input  wire logic             reset_n,    // async reset, active low
  input  wire logic [6:0]       reg_addr,   // register offset
  input  wire logic [8:0]       reg_wdata,  // write data
  input  wire logic             reg_write,  // write strobe
  input  wire logic             reg_read,   // read strobe
  output logic      [8:0]       reg_rdata,  // read data, one cycle after strobe
  output cpr_words_t            words       // all stored words
);

  typedef struct packed {
    cpr_words_t words;
    logic [8:0] rdata;
  } cpr_rf_state_t;

  cpr_rf_state_t s_reg;
  cpr_rf_state_t s_next;
  logic [3:0]    hit;

  assign hit = cpr_decode(reg_addr);

  always_comb begin
    s_next = s_reg;
    // plain read-write storage; unmapped writes are dropped
    if (reg_write && hit[3]) begin
      s_next.words[hit[2:0]] = reg_wdata;
    end
    // a read in the same cycle as a write returns the old word
    if (reg_read) begin
      s_next.rdata = hit[3] ? s_reg.words[hit[2:0]] : 9'h000;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{words: CPR_RST_WORDS, rdata: 9'h000};
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign words     = s_reg.words;

endmodule

// ==== verilog/cpr_top.sv ====
// codec path control: de-emphasis, phase, adc functions and digital routing
// Behaviour
// - three per-dac de-emphasis enables, reset zero, bit n drives dac n+1
// - de-emphasis-all bit forces de-emphasis on all three dacs
// - six polarity bits reset ones; a zero inverts that dac output channel
// - adc high-pass active after reset, bypassed while disable bit set
// - adc runs 128fs, or 64fs for 128fs and 192fs master clocks
// - oversample select bit halves the adc rate; clear after reset
// - mute-both bit mutes both adc channels regardless of single bits
// - any of three primary data inputs can be steered to any dac
// - stream steered to dac1 also feeds spdif and secondary transmitters
// - dac1 source: 00 spdif rx, 10 secondary rx, 11 primary rx; reset 11
// - dacs 2 and 3 use primary rx only; may power off on spdif source
// - spdif on dac1: mode clear uses subframe clock, powers down dacs 2 3
// - primary tx source: 00 spdif, 01 adc, 10 secondary rx; reset 01
// - secondary tx source: 00 spdif, 01 adc, 11 primary rx; reset 00
// - spdif tx source: 00 spdif rx, 01 adc, 10 secondary, 11 primary
// - pass-through bit drives spdif pin from input mux instead of transmitter
`timescale 1ns/100ps
module cpr_top
  import cpr_pkg::*;
(
  input  wire logic              sys_clk,                // 20 MHz system clock
  input  wire logic              reset_n,                // async reset, active low
  input  wire logic [6:0]        reg_addr,               // control register offset
  input  wire logic [8:0]        reg_wdata,              // control write data
  input  wire logic              reg_write,              // control write strobe
  input  wire logic              reg_read,               // control read strobe
  output logic      [8:0]        reg_rdata,              // readback data
  input  wire logic [2:0][1:0]   din_route,              // data input chosen per dac
  input  wire logic [2:0]        mclk_ratio_code,        // adc master clock ratio
  input  wire logic              sample_tick,            // one new audio sample
  input  cpr_sample_t [2:0]      pri_rx_sample,          // primary rx, per data input
  input  cpr_sample_t            sec_rx_sample,          // secondary rx sample
  input  cpr_sample_t            spdif_rx_sample,        // spdif receiver sample
  input  cpr_sample_t            adc_sample,             // adc output sample
  input  wire logic              spdif_tx_bit,           // spdif transmitter line
  input  wire logic              spdif_in_mux_bit,       // spdif input mux line
  output cpr_sample_t [2:0]      dac_sample,             // samples to the dacs
  output cpr_sample_t            pri_tx_sample,          // primary tx sample
  output cpr_sample_t            sec_tx_sample,          // secondary tx sample
  output cpr_sample_t            spdif_tx_sample,        // spdif tx sample
  output logic      [2:0]        deemph_enable,          // de-emphasis per dac
  output logic                   adc_highpass_bypass,    // adc high-pass bypassed
  output logic                   adc_mute_left,          // adc left input muted
  output logic                   adc_mute_right,         // adc right input muted
  output logic      [1:0]        adc_osr_code,           // adc oversampling rate
  output logic                   dac23_powerdown,        // dacs 2 and 3 switched off
  output logic                   dac_rate_from_subframe, // dac rate from subframe clock
  output logic                   spdif_output_pin        // spdif output line
);

  typedef struct packed {
    cpr_cfg_t          cfg;
    cpr_sample_t [2:0] dac;
    cpr_sample_t       pri_tx;
    cpr_sample_t       sec_tx;
    cpr_sample_t       spdif_tx;
    logic [2:0]        deemph;
    logic              hpf_bypass;
    logic              mute_l;
    logic              mute_r;
    logic [1:0]        osr;
    logic              dac23_off;
    logic              rate_subframe;
    logic              spdif_pin;
  } cpr_state_t;

  cpr_state_t s_reg;
  cpr_state_t s_next;
  cpr_words_t words;

  cpr_regfile u_regfile (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_write (reg_write),
    .reg_read  (reg_read),
    .reg_rdata (reg_rdata),
    .words     (words)
  );

  // unpack the stored words into the working settings
  function automatic cpr_cfg_t cfg_from_words(input cpr_words_t w,
                                              input logic [2:0][1:0] rt);
    cpr_cfg_t c;
    c = '0;
    c.dac1_source_field         = w[CPR_IDX_DAC1_SRC][CPR_SRC_LSB+:2];
    c.primary_tx_source_field   = w[CPR_IDX_PRI_TX][CPR_SRC_LSB+:2];
    c.secondary_tx_source_field = w[CPR_IDX_SEC_TX][CPR_SRC_LSB+:2];
    c.spdif_tx_source_field     = w[CPR_IDX_SPDIF_TX][CPR_SPDIF_SRC_LSB+:2];
    c.spdif_through             = w[CPR_IDX_SPDIF_TX][CPR_THROUGH_BIT];
    c.receive_to_dac_mode       = w[CPR_IDX_DAC_CTRL1][CPR_RX2DAC_BIT];
    c.per_dac_deemph_enable     = w[CPR_IDX_DEEMPH][CPR_DEEMPH_LSB+:3];
    c.deemph_all_dacs           = w[CPR_IDX_DEEMPH][CPR_DEEMPH_ALL_BIT];
    c.output_polarity           = w[CPR_IDX_POLARITY][CPR_POLARITY_LSB+:6];
    c.adc_highpass_disable      = w[CPR_IDX_ADC_FUNC][CPR_HPD_BIT];
    c.adc_oversample_select     = w[CPR_IDX_ADC_FUNC][CPR_OSR_BIT];
    c.adc_left_mute             = w[CPR_IDX_ADC_FUNC][CPR_MUTE_L_BIT];
    c.adc_right_mute            = w[CPR_IDX_ADC_FUNC][CPR_MUTE_R_BIT];
    c.adc_both_mute             = w[CPR_IDX_ADC_FUNC][CPR_MUTE_BOTH_BIT];
    c.din_route                 = rt;
    return c;
  endfunction

  // two's complement negate; full-scale negative saturates since +2^23 has no code
  function automatic logic [23:0] invert(input logic [23:0] v);
    if (v == CPR_SAMPLE_MIN) begin
      return CPR_SAMPLE_MAX;
    end
    return ~v + 24'h000001;
  endfunction

  // code 3 names no data input and yields silence
  function automatic cpr_sample_t pick_din(input cpr_sample_t [2:0] pins,
                                           input logic [1:0] sel);
    if (sel == 2'h3) begin
      return '0;
    end
    return pins[sel];
  endfunction

  cpr_cfg_t          c;
  cpr_sample_t [2:0] steered;
  cpr_sample_t [2:0] dac_raw;

  always_comb begin
    s_next  = s_reg;
    c       = cfg_from_words(words, din_route);
    steered = '0;
    dac_raw = '0;
    // the pin follows the settings of the sample in flight, one flop behind the line
    s_next.spdif_pin = s_reg.cfg.spdif_through ? spdif_in_mux_bit : spdif_tx_bit;
    if (sample_tick) begin
      s_next.cfg = c;
      for (int k = 0; k < 3; k++) begin
        steered[k] = pick_din(pri_rx_sample, c.din_route[k]);
      end
      case (c.dac1_source_field)
        CPR_SRC_SPDIF: dac_raw[0] = spdif_rx_sample;
        CPR_SRC_SEC:   dac_raw[0] = sec_rx_sample;
        CPR_SRC_PRI:   dac_raw[0] = steered[0];
        default:       dac_raw[0] = '0;
      endcase
      s_next.dac23_off     = (c.dac1_source_field == CPR_SRC_SPDIF) &&
                             !c.receive_to_dac_mode;
      s_next.rate_subframe = s_next.dac23_off;
      for (int k = 1; k < 3; k++) begin
        dac_raw[k] = s_next.dac23_off ? '0 : steered[k];
      end
      for (int k = 0; k < 3; k++) begin
        s_next.dac[k].left  = c.output_polarity[2*k] ?
                              dac_raw[k].left : invert(dac_raw[k].left);
        s_next.dac[k].right = c.output_polarity[2*k+1] ?
                              dac_raw[k].right : invert(dac_raw[k].right);
      end
      case (c.primary_tx_source_field)
        CPR_SRC_SPDIF: s_next.pri_tx = spdif_rx_sample;
        CPR_SRC_ADC:   s_next.pri_tx = adc_sample;
        CPR_SRC_SEC:   s_next.pri_tx = sec_rx_sample;
        default:       s_next.pri_tx = '0;
      endcase
      case (c.secondary_tx_source_field)
        CPR_SRC_SPDIF: s_next.sec_tx = spdif_rx_sample;
        CPR_SRC_ADC:   s_next.sec_tx = adc_sample;
        CPR_SRC_PRI:   s_next.sec_tx = steered[0];
        default:       s_next.sec_tx = '0;
      endcase
      case (c.spdif_tx_source_field)
        CPR_SRC_SPDIF: s_next.spdif_tx = spdif_rx_sample;
        CPR_SRC_ADC:   s_next.spdif_tx = adc_sample;
        CPR_SRC_SEC:   s_next.spdif_tx = sec_rx_sample;
        CPR_SRC_PRI:   s_next.spdif_tx = steered[0];
        default:       s_next.spdif_tx = '0;
      endcase
      s_next.deemph     = c.deemph_all_dacs ? 3'h7 : c.per_dac_deemph_enable;
      s_next.hpf_bypass = c.adc_highpass_disable;
      s_next.mute_l     = c.adc_left_mute || c.adc_both_mute;
      s_next.mute_r     = c.adc_right_mute || c.adc_both_mute;
      if ((mclk_ratio_code == CPR_RATIO_128FS) || (mclk_ratio_code == CPR_RATIO_192FS)) begin
        s_next.osr = c.adc_oversample_select ? CPR_OSR_32FS : CPR_OSR_64FS;
      end else begin
        s_next.osr = c.adc_oversample_select ? CPR_OSR_64FS : CPR_OSR_128FS;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg               <= '0;
      s_reg.cfg.dac1_source_field       <= CPR_RST_DAC1_SRC[CPR_SRC_LSB+:2];
      s_reg.cfg.primary_tx_source_field <= CPR_RST_PRI_TX[CPR_SRC_LSB+:2];
      s_reg.cfg.output_polarity         <= CPR_RST_POLARITY[CPR_POLARITY_LSB+:6];
      s_reg.osr           <= CPR_OSR_128FS;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dac_sample             = s_reg.dac;
  assign pri_tx_sample          = s_reg.pri_tx;
  assign sec_tx_sample          = s_reg.sec_tx;
  assign spdif_tx_sample        = s_reg.spdif_tx;
  assign deemph_enable          = s_reg.deemph;
  assign adc_highpass_bypass    = s_reg.hpf_bypass;
  assign adc_mute_left          = s_reg.mute_l;
  assign adc_mute_right         = s_reg.mute_r;
  assign adc_osr_code           = s_reg.osr;
  assign dac23_powerdown        = s_reg.dac23_off;
  assign dac_rate_from_subframe = s_reg.rate_subframe;
  assign spdif_output_pin       = s_reg.spdif_pin;

endmodule

// ==== test/cpr_checker.sv ====
// assertion checker for codec path control and routing, bound to the top
`timescale 1ns/100ps
module cpr_checker
  import cpr_pkg::*;
(
  input  wire logic        sys_clk,             // system clock
  input  wire logic        reset_n,             // async reset, active low
  input  wire logic [6:0]  reg_addr,            // register offset
  input  wire logic [8:0]  reg_wdata,           // write data
  input  wire logic        reg_write,           // write strobe
  input  wire logic        sample_tick,         // sample pulse
  input  wire logic [2:0]  mclk_ratio_code,     // master clock ratio
  input  cpr_sample_t      sec_rx_sample,       // secondary rx
  input  cpr_sample_t      spdif_rx_sample,     // spdif rx
  input  cpr_sample_t      adc_sample,          // adc data
  input  wire logic        spdif_tx_bit,        // transmitter line
  input  wire logic        spdif_in_mux_bit,    // input mux line
  input  cpr_sample_t      pri_tx_sample,       // primary tx
  input  cpr_sample_t      spdif_tx_sample,     // spdif tx
  input  wire logic [2:0]  deemph_enable,       // de-emphasis
  input  wire logic        adc_highpass_bypass, // high-pass bypass
  input  wire logic        adc_mute_left,       // left mute
  input  wire logic        adc_mute_right,      // right mute
  input  wire logic [1:0]  adc_osr_code,        // adc rate
  input  wire logic        dac23_powerdown,     // dacs 2 and 3 off
  input  wire logic        spdif_output_pin     // spdif pin
);
  logic [8:0]  sh [32];
  logic        thr_q;
  cpr_sample_t pri_exp;

  // shadow of the low offsets; unmapped slots are stored but never looked at
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++)
        sh[i] <= 9'h000;
      sh[12] <= CPR_RST_DAC1_SRC;
      sh[13] <= CPR_RST_PRI_TX;
      sh[29] <= CPR_RST_ADC_FUNC;
      thr_q <= 1'b0;
    end else begin
      if (reg_write && reg_addr[6:5] == 2'h0)
        sh[reg_addr[4:0]] <= reg_wdata;
      if (sample_tick)
        thr_q <= sh[30][3];
    end
  end

  always_comb begin
    case (sh[13][8:7])
      2'h0: pri_exp = spdif_rx_sample;
      2'h1: pri_exp = adc_sample;
      2'h2: pri_exp = sec_rx_sample;
      default: pri_exp = '0;
    endcase
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_deemph_select: assert property (sample_tick |=> deemph_enable ==
    ($past(sh[17][4]) ? 3'h7 : $past(sh[17][2:0]))) else $error("de-emphasis enables wrong");
  a_hpf_bypass: assert property (sample_tick |=>
    adc_highpass_bypass == $past(sh[29][4])) else $error("high-pass bypass wrong");
  a_left_mute: assert property (sample_tick |=>
    adc_mute_left == $past(sh[29][0] | sh[29][2])) else $error("left mute wrong");
  a_right_mute: assert property (sample_tick |=>
    adc_mute_right == $past(sh[29][1] | sh[29][2])) else $error("right mute wrong");
  a_osr_rate: assert property (sample_tick |=> adc_osr_code ==
    ($past(mclk_ratio_code) < 3'h2 ? 2'h1 : 2'h0) + 2'($past(sh[29][3])))
    else $error("adc oversampling code wrong");
  a_dac23_off: assert property (sample_tick |=> dac23_powerdown ==
    ($past(sh[12][8:7]) == 2'h0 && !$past(sh[15][8]))) else $error("dac 2/3 power wrong");
  a_pri_route: assert property (sample_tick |=> pri_tx_sample == $past(pri_exp))
    else $error("primary tx source wrong");
  a_through_pin: assert property ($past(reset_n) |-> spdif_output_pin ==
    $past(thr_q ? spdif_in_mux_bit : spdif_tx_bit)) else $error("spdif pin source wrong");
  a_tx_holds: assert property (!sample_tick |=> $stable(spdif_tx_sample))
    else $error("spdif tx sample moved without a tick");

  cover property (sample_tick && sh[12][8:7] == 2'h0);
  cover property (sample_tick && sh[30][3]);
  cover property (sample_tick && sh[29][2]);
endmodule

bind cpr_top cpr_checker i_chk (.*);

// ==== test/cpr_audio_proc.sv ====
// behavioural audio processor feeding sample streams on every tick
`timescale 1ns/100ps
module cpr_audio_proc
  import cpr_pkg::*;
(
  input  wire logic        sys_clk,         // system clock
  input  wire logic        reset_n,         // async reset, active low
  input  wire logic        sample_tick,     // one sample per pulse
  output cpr_sample_t [2:0] pri_rx_sample,  // primary rx per data input
  output cpr_sample_t      sec_rx_sample,   // secondary rx
  output cpr_sample_t      spdif_rx_sample, // spdif receiver
  output cpr_sample_t      adc_sample       // adc output
);
  logic [7:0] seq_reg;

  // data moves on only once the device has taken it, as at a frame boundary
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      seq_reg <= 8'h00;
    else if (sample_tick)
      seq_reg <= seq_reg + 8'h01;
  end

  // each source has its own tag byte so a wrong route can never match
  always_comb begin
    for (int k = 0; k < 3; k++)
      pri_rx_sample[k] = {8'ha0 + 8'(k), 8'h5a, seq_reg, 8'h30 + 8'(k), 8'ha5, seq_reg};
    sec_rx_sample = {8'hc4, 8'h12, seq_reg, 8'h44, 8'h21, seq_reg};
    spdif_rx_sample = {8'he8, 8'h34, seq_reg, 8'h58, 8'h43, seq_reg};
    adc_sample = {8'h6c, 8'h56, seq_reg, 8'hfc, 8'h65, seq_reg};
  end
endmodule

// ==== test/cpr_top_tb.sv ====
// self-checking testbench for codec path control and routing
`timescale 1ns/100ps
module cpr_top_tb
  import cpr_pkg::*;
;
  logic              sys_clk, reset_n, reg_write, reg_read, sample_tick;
  logic              spdif_tx_bit, spdif_in_mux_bit, spdif_output_pin;
  logic              adc_highpass_bypass, adc_mute_left, adc_mute_right;
  logic              dac23_powerdown, dac_rate_from_subframe;
  logic [6:0]        reg_addr;
  logic [8:0]        reg_wdata, reg_rdata;
  logic [2:0][1:0]   din_route;
  logic [2:0]        mclk_ratio_code, deemph_enable;
  logic [1:0]        adc_osr_code;
  cpr_sample_t [2:0] pri_rx_sample, dac_sample, ip;
  cpr_sample_t       sec_rx_sample, spdif_rx_sample, adc_sample, isec, isp, iadc;
  cpr_sample_t       pri_tx_sample, sec_tx_sample, spdif_tx_sample;
  int                err_count = 0;
  int                tests_run = 0;
  int                cyc = 0;

  cpr_top        i_dut (.*);
  cpr_audio_proc i_proc (.*);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(48'(reg_rdata), 48'(e));
  endtask

  // inputs are copied 1 ns after the tick is raised, ahead of the taking edge, as the partner moves on at it
  task automatic tick();
    @(posedge sys_clk);
    sample_tick <= 1'b1;
    #1 {ip, isec, isp, iadc} = {pri_rx_sample, sec_rx_sample, spdif_rx_sample, adc_sample};
    @(posedge sys_clk);
    sample_tick <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  function automatic cpr_sample_t pol(input cpr_sample_t s, input logic [1:0] p);
    return {p[0] ? s.left : (s.left == CPR_SAMPLE_MIN ? CPR_SAMPLE_MAX : -s.left),
            p[1] ? s.right : (s.right == CPR_SAMPLE_MIN ? CPR_SAMPLE_MAX : -s.right)};
  endfunction

  task automatic t_regs();
    logic [6:0] ofs [8] = '{7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h11, 7'h12, 7'h1d, 7'h1e};
    for (int i = 0; i < 8; i++)
      rd(ofs[i], CPR_RST_WORDS[i]);
    wr(7'h10, 9'h1ff);
    rd(7'h10, 9'h000);
    wr(CPR_OFS_DEEMPH, 9'h1ff);
    rd(CPR_OFS_DEEMPH, 9'h1ff);
  endtask

  task automatic t_deemph();
    for (int i = 0; i < 16; i++) begin
      wr(CPR_OFS_DEEMPH, {4'h0, i[3], 1'b0, i[2:0]});
      tick();
      chk(48'(deemph_enable), 48'(i[3] ? 3'h7 : i[2:0]));
    end
  endtask

  task automatic t_adc();
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 32; i++) begin
        wr(CPR_OFS_ADC_FUNC, 9'h040 | 9'(i));
        mclk_ratio_code <= 3'(r);
        tick();
        chk(48'(adc_highpass_bypass), 48'(i[4]));
        chk(48'({adc_mute_left, adc_mute_right}),
            48'({i[0] | i[2], i[1] | i[2]}));
        chk(48'(adc_osr_code), 48'(i[3] + (r < 2 ? 1 : 0)));
      end
  endtask

  task automatic t_dacs();
    logic [2:0][1:0] rt [4] = '{6'h06, 6'h12, 6'h30, 6'h2b};
    logic [5:0] pv [2] = '{6'h2a, 6'h15};
    for (int p = 0; p < 2; p++) begin
      wr(CPR_OFS_POLARITY, {3'h0, pv[p]});
      for (int j = 0; j < 4; j++) begin
        din_route <= rt[j];
        tick();
        for (int k = 0; k < 3; k++)
          chk(dac_sample[k],
              pol(rt[j][k] == 2'h3 ? '0 : ip[rt[j][k]], pv[p][2*k +: 2]));
      end
    end
  endtask

  task automatic t_txs();
    cpr_sample_t src [4];
    logic [1:0] s;
    wr(CPR_OFS_POLARITY, 9'h03f);
    din_route <= {2'h2, 2'h0, 2'h1};
    for (int m = 0; m < 5; m++) begin
      s = 2'(m);
      wr(CPR_OFS_DAC1_SRC, {s, 7'h00});
      wr(CPR_OFS_PRI_TX, {s, 7'h00});
      wr(CPR_OFS_SEC_TX, {s, 7'h00});
      wr(CPR_OFS_SPDIF_TX, {7'h00, s});
      if (m == 4)
        wr(CPR_OFS_DAC_CTRL1, 9'h100);
      tick();
      src = '{isp, iadc, isec, ip[1]};
      chk(spdif_tx_sample, src[s]);
      chk(pri_tx_sample, s == 2'h3 ? '0 : src[s]);
      chk(sec_tx_sample, s == 2'h2 ? '0 : src[s]);
      chk(dac_sample[0], s == 2'h1 ? '0 : src[s]);
      chk(dac_sample[1], (s == 2'h0 && m < 4) ? '0 : ip[0]);
      chk(48'({dac23_powerdown, dac_rate_from_subframe}),
          48'(s == 2'h0 && m < 4 ? 3 : 0));
    end
  endtask

  task automatic t_thru();
    logic e;
    for (int t = 0; t < 2; t++) begin
      wr(CPR_OFS_SPDIF_TX, {5'h00, t[0], 3'h0});
      tick();
      for (int i = 0; i < 8; i++) begin
        @(posedge sys_clk);
        spdif_tx_bit <= i[0];
        spdif_in_mux_bit <= ~i[1];
        #1;
        if (i > 0)
          chk(48'(spdif_output_pin), 48'(e));
        e = t[0] ? ~i[1] : i[0];
      end
    end
  endtask

  // generous ceiling: the full sequence needs well under ten thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  initial begin
    {reset_n, reg_write, reg_read, sample_tick, spdif_tx_bit, spdif_in_mux_bit} = '0;
    {reg_addr, reg_wdata} = '0;
    din_route = {2'h2, 2'h1, 2'h0};
    mclk_ratio_code = 3'h2;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_deemph();
    t_adc();
    t_dacs();
    t_txs();
    t_thru();
    results();
  end
endmodule
